// ===== bench/eca_chk.sv
/* checker for the entropy CSR access check at the eca_top ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module eca_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        ACC_VALID,
  input wire logic [2:0]  ACC_TIER,
  input wire logic        ACC_WRITE,
  input wire logic [31:0] SEED_WORD,
  input wire logic        SEED_POP,
  input wire logic        ACC_DONE,
  input wire logic        ACC_ALLOW,
  input wire logic        ACC_TRAP,
  input wire logic [4:0]  ACC_CAUSE,
  input wire logic        RD_WE,
  input wire logic [31:0] RD_DATA
);
  // ==============================
  // verdict relations
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  AST_LAT: assert property (ACC_VALID |=> ACC_DONE)
    else $error("verdict not one cycle after request");
  AST_QUIET: assert property (!ACC_VALID |=> !ACC_DONE && !SEED_POP)
    else $error("verdict or pop without request");
  AST_RDONLY: assert property (ACC_VALID && !ACC_WRITE |=>
    ACC_TRAP && ACC_CAUSE == 5'h02) else $error("read-only not illegal");
  AST_MACH: assert property (ACC_VALID && ACC_WRITE &&
    ACC_TIER == 3'h3 |=> ACC_ALLOW) else $error("machine access refused");
  AST_GUEST: assert property (ACC_VALID && ACC_TIER[2:1] == 2'b11
    |=> ACC_TRAP) else $error("guest access not trapped");
  AST_NOSIDE: assert property (ACC_TRAP |-> !SEED_POP && !RD_WE
    && RD_DATA == 32'h0) else $error("trapped access had effect");
  AST_DATA: assert property (ACC_VALID ##1 ACC_ALLOW |-> RD_WE
    && RD_DATA == $past(SEED_WORD)) else $error("allowed data wrong");
  AST_ONE: assert property (ACC_DONE |-> ACC_ALLOW ^ ACC_TRAP)
    else $error("verdict not exactly one of allow or trap");
  cover property (ACC_DONE && ACC_CAUSE == 5'h16);
  cover property (ACC_ALLOW && ACC_TIER != 3'h3);
  cover property (ACC_TRAP ##1 ACC_DONE);
endmodule : eca_chk
bind eca_top eca_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .ACC_VALID(ACC_VALID), .ACC_TIER(ACC_TIER), .ACC_WRITE(ACC_WRITE),
  .SEED_WORD(SEED_WORD), .SEED_POP(SEED_POP), .ACC_DONE(ACC_DONE),
  .ACC_ALLOW(ACC_ALLOW), .ACC_TRAP(ACC_TRAP), .ACC_CAUSE(ACC_CAUSE),
  .RD_WE(RD_WE), .RD_DATA(RD_DATA));
`default_nettype wire

// ===== bench/eca_stage.sv
/* execute stage model issuing entropy CSR accesses.
   assumes the caller calls issue once at a time. */
`timescale 1ns/1ns
`default_nettype none
module eca_stage (
  input  wire logic   clk,
  output logic        acc_valid,
  output logic [2:0]  acc_tier,
  output logic        acc_write,
  output logic [31:0] seed_word
);
  // ==============================
  // request driver
  initial begin
    acc_valid = 1'b0;
    acc_tier  = 3'h0;
    acc_write = 1'b0;
    seed_word = 32'h0;
  end
  // gap idle cycles give prompt or slow issue
  task automatic issue(input logic [2:0] t, input logic w,
                       input logic [31:0] s, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_tier  <= t;
    acc_write <= w;
    seed_word <= s;
    @(posedge clk);
    acc_valid <= 1'b0;
    // inverted idle values so stale data never passes
    acc_tier  <= ~t;
    acc_write <= ~w;
    seed_word <= ~s;
  endtask : issue
endmodule : eca_stage
`default_nettype wire

// ===== bench/test_entropy_csr_access_check.sv
/* self-checking bench for eca_top: verdict matrix, enables, irq.
   assumes eca_stage drives the access port. */
`timescale 1ns/1ns
`default_nettype none
module test_entropy_csr_access_check;
  logic SYS_CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, RD_DATA, SEED_WORD;
  logic ACC_VALID, ACC_WRITE, SEED_POP, ACC_DONE, ACC_ALLOW, ACC_TRAP;
  logic RD_WE, AVS_WAITREQUEST, IRQ;
  logic [2:0] ACC_TIER;
  logic [4:0] ACC_CAUSE, ec;
  logic [31:0] q, sd;
  int mismatches = 0, checked = 0, cyc = 0, ntrap = 0, n = 0;
  logic [2:0] tiers [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
  // ==============================
  // harness
  always #2 SYS_CLK = ~SYS_CLK;
  eca_top uut (.SYS_CLK, .RST, .ACC_VALID, .ACC_TIER, .ACC_WRITE,
    .SEED_WORD, .SEED_POP, .ACC_DONE, .ACC_ALLOW, .ACC_TRAP, .ACC_CAUSE,
    .RD_WE, .RD_DATA, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ);
  eca_stage u_stage (.clk(SYS_CLK), .acc_valid(ACC_VALID),
    .acc_tier(ACC_TIER), .acc_write(ACC_WRITE), .seed_word(SEED_WORD));
  task automatic avs(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge SYS_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= d;
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask : avs
  function automatic logic [4:0] cause(logic [2:0] t, logic w,
                                       logic s, logic u);
    if (!w) return 5'h02;
    case (t)
      3'h3: return 5'h00;
      3'h0: return u ? 5'h00 : 5'h02;
      3'h1, 3'h2: return s ? 5'h00 : 5'h02;
      3'h6, 3'h7: return s ? 5'h16 : 5'h02;
      default: return 5'h02;
    endcase
  endfunction : cause
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // budget far above the ~200 cycles the tests need
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      close_out;
    end
  end
  // ==============================
  // tests
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST <= 1'b0;
    avs(1'b0, 4'h0, 32'h0); `CHK(q, 32'h0)
    avs(1'b0, 4'h2, 32'h0); `CHK(q, 32'h0)
    avs(1'b1, 4'h8, 32'h2);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      avs(1'b1, 4'h0, 32'(c) << 8);
      avs(1'b0, 4'h0, 32'h0); `CHK(q, 32'(c) << 8)
      for (int i = 0; i < 12; i++) begin
        sd = 32'h5EED0000 + 32'(n);
        ec = cause(tiers[i/2], i[0], c[1], c[0]);
        ntrap += int'(ec != 5'h00);
        u_stage.issue(tiers[i/2], i[0], sd, n % 3);
        n++;
        @(negedge SYS_CLK);
        `CHK({ACC_DONE, ACC_ALLOW, ACC_TRAP, SEED_POP, RD_WE, ACC_CAUSE}, {1'b1, ec == 5'h00, ec != 5'h00, ec == 5'h00, ec == 5'h00, ec})
        `CHK(RD_DATA, ec == 5'h00 ? sd : 32'h0)
      end
    end
    u_stage.issue(3'h4, 1'b1, 32'h0, 0);
    ntrap++;
    @(negedge SYS_CLK);
    `CHK({ACC_TRAP, ACC_ALLOW, ACC_CAUSE}, {1'b1, 1'b0, 5'h02})
    $display("test matrix done");
    `CHK(IRQ, 1'b1)
    avs(1'b0, 4'h4, 32'h0); `CHK(q, 32'h7)
    avs(1'b0, 4'hC, 32'h0); `CHK(q, 32'(ntrap))
    `CHK(IRQ, 1'b0)
    u_stage.issue(3'h6, 1'b1, 32'h0, 0);
    repeat (3) @(negedge SYS_CLK);
    `CHK(IRQ, 1'b0)
    avs(1'b1, 4'h8, 32'h7);
    repeat (2) @(negedge SYS_CLK);
    `CHK(IRQ, 1'b1)
    $display("test irq done");
    close_out;
  end
endmodule : test_entropy_csr_access_check
`default_nettype wire

// ===== src/eca_decide.sv
/*
  Combinational verdict for one entropy CSR access.
  Assumes the caller registers the verdict; no state lives here.
*/
`timescale 1ns/1ns
`default_nettype none
module eca_decide (
  input  wire logic [2:0]       tier,
  input  wire logic             does_write,
  input  wire logic             sseed,
  input  wire logic             useed,
  output eca_pkg::eca_verdict_t verdict
);
  always_comb begin
    verdict = eca_pkg::ECA_ILLEGAL;
    if (!does_write) begin
      verdict = eca_pkg::ECA_ILLEGAL;
    end else if (tier == eca_pkg::ECA_MACHINE) begin
      verdict = eca_pkg::ECA_ALLOW;
    end else if (tier == eca_pkg::ECA_USER) begin
      verdict = useed ? eca_pkg::ECA_ALLOW
                      : eca_pkg::ECA_ILLEGAL;
    end else if (tier == eca_pkg::ECA_SUPER ||
                 tier == eca_pkg::ECA_HYP_KERNEL) begin
      verdict = sseed ? eca_pkg::ECA_ALLOW
                      : eca_pkg::ECA_ILLEGAL;
    end else if (tier == eca_pkg::ECA_GUEST_KERN ||
                 tier == eca_pkg::ECA_GUEST_APP) begin
      // user enable deliberately not consulted here
      verdict = sseed ? eca_pkg::ECA_VIRTUAL
                      : eca_pkg::ECA_ILLEGAL;
    end else begin
      verdict = eca_pkg::ECA_ILLEGAL;
    end
  end
endmodule : eca_decide
`default_nettype wire

// ===== src/eca_params.svh
/*
  Constants for the entropy CSR access check: field positions of the
  enable bits, reset values, field widths and cause codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ECA_PARAMS_SVH
`define ECA_PARAMS_SVH

`define ECA_SSEED_BIT       9
`define ECA_USEED_BIT       8
`define ECA_CFG_W           32
`define ECA_SSEED_RST       1'b0
`define ECA_USEED_RST       1'b0
`define ECA_CAUSE_W         5
`define ECA_CAUSE_ILLEGAL   5'h02
`define ECA_CAUSE_VIRTUAL   5'h16
`define ECA_CAUSE_NONE      5'h00
`define ECA_SEED_W          32

`endif

// ===== src/eca_pkg.sv
/*
  Types of the entropy CSR access check.
  Assumes no surroundings beyond the parameter header.
*/
package eca_pkg;
  // privilege tiers, gray coded in the order user, supervisor, machine
  typedef enum logic [2:0] {
    ECA_USER        = 3'h0,
    ECA_SUPER       = 3'h1,
    ECA_MACHINE     = 3'h3,
    ECA_HYP_KERNEL  = 3'h2,
    ECA_GUEST_KERN  = 3'h6,
    ECA_GUEST_APP   = 3'h7
  } eca_tier_t;

  typedef enum logic [1:0] {
    ECA_ALLOW   = 2'h0,
    ECA_ILLEGAL = 2'h1,
    ECA_VIRTUAL = 2'h3
  } eca_verdict_t;
endpackage : eca_pkg

// ===== src/eca_top.sv
/*
  Entropy CSR access check with the two enable bits of the machine
  security configuration register and an Avalon-MM register slave.
  Assumes the execute stage presents one access at a time as a
  one-cycle request on SYS_CLK; verdict follows one cycle later.

// Function
// - machine tier read-write access to entropy CSR always allowed
// - read without write traps illegal at every tier
// - supervisor enable at bit 9, user enable at bit 8
// - user or supervisor tiers with enable clear trap illegal
// - user or supervisor tiers with enable set complete normally
// - guest tiers always trap; virtual only for write with sseed
// - user enable never affects guest tier exception type
// - either enable may be hardwired read-only zero
// - missing supervisor or user mode ties its enable to zero
// - both enables take a defined reset value
// - without entropy extension both enables tie to zero
// - listed instructions keep operand-independent latency
// - fusion or cracking only deterministic, never operand based
// - loads, stores, branches exempt; no instruction mandated
*/
`timescale 1ns/1ns
`default_nettype none
`include "eca_params.svh"
module eca_top #(
  parameter bit HAS_SUPER   = 1'b1,
  parameter bit HAS_USER    = 1'b1,
  parameter bit HAS_ENTROPY = 1'b1,
  parameter bit SSEED_RO0   = 1'b0,
  parameter bit USEED_RO0   = 1'b0
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // access request from the execute stage
  input  wire logic        ACC_VALID,
  input  wire logic [2:0]  ACC_TIER,
  input  wire logic        ACC_WRITE,
  // entropy word from the source, taken only on allowed access
  input  wire logic [31:0] SEED_WORD,
  output logic             SEED_POP,
  output logic             ACC_DONE,
  output logic             ACC_ALLOW,
  output logic             ACC_TRAP,
  output logic [4:0]       ACC_CAUSE,
  output logic             RD_WE,
  output logic [31:0]      RD_DATA,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ
);
  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [3:0] A_CFG    = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h4;
  localparam logic [3:0] A_MASK   = 4'h8;
  localparam logic [3:0] A_COUNT  = 4'hC;

  // status bits: 0 allowed, 1 illegal trap, 2 virtual trap
  localparam int EV_W = 3;

  logic              sseed;
  logic              useed;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   mask;
  logic [15:0]       trap_count;
  logic              ack;
  logic              read_hit;
  eca_pkg::eca_verdict_t verdict;
  logic [EV_W-1:0]   event_now;
  logic              cfg_wr;
  logic              sseed_keep;
  logic              useed_keep;

  // ==========================================================
  // enable bits of the security configuration
  // ==========================================================
  // an enable is storable only if its mode and the extension exist
  assign sseed_keep = HAS_SUPER && HAS_ENTROPY && !SSEED_RO0;
  assign useed_keep = HAS_USER && HAS_ENTROPY && !USEED_RO0;
  assign cfg_wr = AVS_WRITE && !ack && AVS_ADDRESS == A_CFG
                  && AVS_BYTEENABLE[1];

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sseed <= `ECA_SSEED_RST;
      useed <= `ECA_USEED_RST;
    end else if (cfg_wr) begin
      // unsupported bits drop the write so a read-back shows zero
      sseed <= AVS_WRITEDATA[`ECA_SSEED_BIT] & sseed_keep;
      useed <= AVS_WRITEDATA[`ECA_USEED_BIT] & useed_keep;
    end
  end

  // ==========================================================
  // access verdict
  // ==========================================================
  eca_decide u_decide (
    .tier       (ACC_TIER),
    .does_write (ACC_WRITE),
    .sseed      (sseed),
    .useed      (useed),
    .verdict    (verdict)
  );

  // verdict settles in one fixed cycle whatever the operands hold,
  // so timing never reveals entropy bits; no instruction is mandated
  // here and memory or branch latency is outside this block
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ACC_DONE  <= 1'b0;
      ACC_ALLOW <= 1'b0;
      ACC_TRAP  <= 1'b0;
      ACC_CAUSE <= `ECA_CAUSE_NONE;
    end else begin
      ACC_DONE  <= ACC_VALID;
      ACC_ALLOW <= ACC_VALID && verdict == eca_pkg::ECA_ALLOW;
      ACC_TRAP  <= ACC_VALID && verdict != eca_pkg::ECA_ALLOW;
      if (!ACC_VALID) begin
        ACC_CAUSE <= `ECA_CAUSE_NONE;
      end else if (verdict == eca_pkg::ECA_VIRTUAL) begin
        ACC_CAUSE <= `ECA_CAUSE_VIRTUAL;
      end else if (verdict == eca_pkg::ECA_ILLEGAL) begin
        ACC_CAUSE <= `ECA_CAUSE_ILLEGAL;
      end else begin
        ACC_CAUSE <= `ECA_CAUSE_NONE;
      end
    end
  end

  // destination write and entropy pop only on an allowed access
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SEED_POP <= 1'b0;
      RD_WE    <= 1'b0;
      RD_DATA  <= 32'h0000_0000;
    end else begin
      SEED_POP <= ACC_VALID && verdict == eca_pkg::ECA_ALLOW;
      RD_WE    <= ACC_VALID && verdict == eca_pkg::ECA_ALLOW;
      if (ACC_VALID && verdict == eca_pkg::ECA_ALLOW) begin
        RD_DATA <= SEED_WORD;
      end else begin
        RD_DATA <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // events, status and interrupt
  // ==========================================================
  assign event_now[0] = ACC_VALID && verdict == eca_pkg::ECA_ALLOW;
  assign event_now[1] = ACC_VALID && verdict == eca_pkg::ECA_ILLEGAL;
  assign event_now[2] = ACC_VALID && verdict == eca_pkg::ECA_VIRTUAL;
  assign read_hit = AVS_READ && !ack && AVS_ADDRESS == A_STATUS;

  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi = gi + 1) begin : g_stat
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          status[gi] <= 1'b0;
        end else if (event_now[gi]) begin
          // a new event wins over the read clear in the same cycle
          status[gi] <= 1'b1;
        end else if (read_hit) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mask <= 3'h0;
    end else if (AVS_WRITE && !ack && AVS_ADDRESS == A_MASK
                 && AVS_BYTEENABLE[0]) begin
      mask <= AVS_WRITEDATA[EV_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      trap_count <= 16'h0000;
    end else if (ACC_VALID && verdict != eca_pkg::ECA_ALLOW
                 && trap_count != 16'hFFFF) begin
      trap_count <= trap_count + 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & mask);
    end
  end

  // ==========================================================
  // avalon-mm slave: one wait cycle, answer on the second edge
  // ==========================================================
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      if (AVS_ADDRESS == A_CFG) begin
        AVS_READDATA <= {22'h000000, sseed, useed, 8'h00};
      end else if (AVS_ADDRESS == A_STATUS) begin
        AVS_READDATA <= {29'h0000000, status};
      end else if (AVS_ADDRESS == A_MASK) begin
        AVS_READDATA <= {29'h0000000, mask};
      end else if (AVS_ADDRESS == A_COUNT) begin
        AVS_READDATA <= {16'h0000, trap_count};
      end else begin
        AVS_READDATA <= 32'h0000_0000;
      end
    end
  end
endmodule : eca_top
`default_nettype wire
